//--- harvard_core.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Each instruction is one 12-bit program word.
// - Separate 12-bit program bus delivers one word each instruction cycle.
// - Next instruction is fetched while the current one executes.
// - Instructions finish in one instruction cycle except flow changes.
// - Program space is a parameter: 512, 1K or 2K words, all on chip.
// - Register files reachable directly or through the pointer register.
// - Special registers including program counter live in data space.
// - 8-bit ALU adds, subtracts, shifts and does logic.
// - Arithmetic is two's complement.
// - Two-operand ops use accumulator plus file register or immediate.
// - Single-operand ops act on accumulator or one file register.
// - Accumulator is 8 bits and has no data address.
// - ALU updates carry, nibble carry and zero flags per instruction.
// - In subtraction carry and nibble carry mean no borrow.
// - Cycle is four oscillator periods; cycle-rate output at quarter rate in RC mode, low otherwise.
module harvard_core
   import core_pkg::*;
#(
   parameter int unsigned PROG_WORDS = PROG_WORDS_DEF
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Oscillator mode strap, high selects RC mode
   input wire logic rc_mode,
   // Program memory
   output logic [10:0] prog_addr,
   input wire logic [INSN_W-1:0] prog_data,
   // Data register file
   output dmem_req_t dmem_req,
   input wire logic [DATA_W-1:0] dmem_rdata,
   // Observation
   output logic [DATA_W-1:0] acc_out,
   output logic [DATA_W-1:0] status_out,
   output logic cycle_rate_output
);

   localparam int unsigned PC_W = $clog2(PROG_WORDS);
   // Mask is a constant so the reset branch can use it as well
   localparam logic [10:0] PC_MASK = 11'((1 << PC_W) - 1);

   // ****************************************************
   // Parameter check
   // ****************************************************
   if (PROG_WORDS != 512 && PROG_WORDS != 1024 && PROG_WORDS != 2048)
   begin : g_bad
      $error("PROG_WORDS must be 512, 1024 or 2048");
   end

   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      logic [1:0] phase;
      logic [10:0] pc;
      logic [10:0] stack0;
      logic [10:0] stack1;
      logic [INSN_W-1:0] ir;
      logic flush;
      logic [DATA_W-1:0] acc;
      logic [DATA_W-1:0] status;
      logic [DATA_W-1:0] pointer;
      logic [DATA_W-1:0] timer;
      dmem_req_t dreq;
      logic clk_out;
      logic rc_s1;
      logic rc_s2;
   } state_t;

   state_t s_q;
   state_t s_d;
   dec_t dec;
   logic [DATA_W-1:0] opa;
   logic [DATA_W-1:0] opb;
   logic [DATA_W-1:0] fval;
   logic [DATA_W-1:0] res;
   logic [4:0] ea;
   logic c_out;
   logic n_out;
   logic [DATA_W:0] wide;
   logic [4:0] nib;
   logic [10:0] pc_mask;

   assign pc_mask = PC_MASK;

   // ****************************************************
   // Decode
   // ****************************************************
   // Only a compact subset of the 12-bit formats is decoded
   always_comb
   begin
      dec = '0;
      dec.op = ALU_PASS_B;
      unique case (s_q.ir[11:10])
         2'b00:
         begin
            dec.to_file = s_q.ir[5];
            dec.wr_acc = ~s_q.ir[5];
            // Add and subtract codes follow the package opcodes
            case (s_q.ir[9:6])
               4'h1: dec.op = ALU_CLR;
               OP_SUB_F[3:0]: dec.op = ALU_SUB;
               4'h3: dec.op = ALU_DEC;
               4'h4: dec.op = ALU_OR;
               4'h5: dec.op = ALU_AND;
               4'h6: dec.op = ALU_XOR;
               OP_ADD_F[3:0]: dec.op = ALU_ADD;
               4'h8: dec.op = ALU_PASS_B;
               4'h9: dec.op = ALU_COM;
               4'ha: dec.op = ALU_INC;
               4'hc: dec.op = ALU_RRF;
               4'hd: dec.op = ALU_RLF;
               4'he: dec.op = ALU_SWAP;
               default: dec.op = ALU_PASS_B;
            endcase
            dec.set_null = dec.op inside {ALU_CLR, ALU_SUB, ALU_DEC, ALU_OR, ALU_AND,
               ALU_XOR, ALU_ADD, ALU_PASS_B, ALU_COM, ALU_INC};
            dec.set_ovf = dec.op inside {ALU_ADD, ALU_SUB, ALU_RLF, ALU_RRF};
            dec.set_nib = dec.op inside {ALU_ADD, ALU_SUB};
            if (s_q.ir[11:0] == NOP_WORD)
            begin
               dec.wr_acc = 1'b0;
               dec.set_null = 1'b0;
            end
         end
         2'b10:
         begin
            dec.jump = 1'b1;
            dec.call = ~s_q.ir[9];
         end
         2'b11:
         begin
            dec.use_imm = 1'b1;
            dec.wr_acc = 1'b1;
            case (s_q.ir[9:8])
               2'b00: dec.op = ALU_PASS_B;
               2'b01: dec.op = ALU_OR;
               2'b10: dec.op = ALU_AND;
               default: dec.op = ALU_XOR;
            endcase
            dec.set_null = (s_q.ir[9:8] != 2'b00);
         end
         default:
         begin
            dec.ret = (s_q.ir[9:8] == 2'b00);
            dec.jump = dec.ret;
            dec.wr_acc = dec.ret;
         end
      endcase
   end

   // ****************************************************
   // Operand fetch and ALU
   // ****************************************************
   // Pointer register supplies the address for location zero
   always_comb
   begin
      ea = (s_q.ir[4:0] == F_INDIRECT) ? s_q.pointer[4:0] : s_q.ir[4:0];
      case (ea)
         F_TIMER: fval = s_q.timer;
         F_PCL: fval = s_q.pc[7:0];
         F_STATUS: fval = s_q.status;
         F_POINTER: fval = s_q.pointer;
         default: fval = dmem_rdata;
      endcase
      opa = s_q.acc;
      opb = dec.use_imm ? s_q.ir[7:0] : fval;
      wide = '0;
      nib = '0;
      c_out = s_q.status[ST_OVF];
      n_out = s_q.status[ST_NIB];
      case (dec.op)
         ALU_ADD:
         begin
            wide = {1'b0, opb} + {1'b0, opa};
            nib = {1'b0, opb[3:0]} + {1'b0, opa[3:0]};
            res = wide[7:0];
            c_out = wide[8];
            n_out = nib[4];
         end
         ALU_SUB:
         begin
            wide = {1'b0, opb} + {1'b0, ~opa} + 9'h001;
            nib = {1'b0, opb[3:0]} + {1'b0, ~opa[3:0]} + 5'h01;
            res = wide[7:0];
            c_out = wide[8];
            n_out = nib[4];
         end
         ALU_AND: res = opa & opb;
         ALU_OR: res = opa | opb;
         ALU_XOR: res = opa ^ opb;
         ALU_COM: res = ~opb;
         ALU_INC: res = opb + 8'h01;
         ALU_DEC: res = opb - 8'h01;
         ALU_RLF:
         begin
            res = {opb[6:0], s_q.status[ST_OVF]};
            c_out = opb[7];
         end
         ALU_RRF:
         begin
            res = {s_q.status[ST_OVF], opb[7:1]};
            c_out = opb[0];
         end
         ALU_SWAP: res = {opb[3:0], opb[7:4]};
         ALU_CLR: res = 8'h00;
         default: res = opb;
      endcase
   end

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb
   begin
      s_d = s_q;
      s_d.rc_s1 = rc_mode;
      s_d.rc_s2 = s_q.rc_s1;
      s_d.phase = s_q.phase + 2'd1;
      s_d.dreq.we = 1'b0;
      // Cycle-rate output high for the first half of the cycle
      s_d.clk_out = s_q.rc_s2 & (s_d.phase < 2'd2);
      s_d.dreq.addr = ea;
      // Program state and timer advance on the last quarter only
      if (s_q.phase == 2'(QUARTERS - 1))
      begin
         s_d.ir = prog_data;
         s_d.pc = (s_q.pc + 11'd1) & pc_mask;
         s_d.flush = 1'b0;
         s_d.timer = s_q.timer + 8'h01;
         if (!s_q.flush)
         begin
            if (dec.set_null)
               s_d.status[ST_NULL] = (res == 8'h00);
            if (dec.set_ovf)
               s_d.status[ST_OVF] = c_out;
            if (dec.set_nib)
               s_d.status[ST_NIB] = n_out;
            if (dec.wr_acc)
               s_d.acc = dec.ret ? s_q.ir[7:0] : res;
            if (dec.to_file)
            begin
               case (ea)
                  F_TIMER: s_d.timer = res;
                  F_STATUS: s_d.status = res;
                  F_POINTER: s_d.pointer = res;
                  F_PCL:
                  begin
                     s_d.pc = {s_q.pc[10:8], res} & pc_mask;
                     s_d.flush = 1'b1;
                  end
                  default:
                  begin
                     s_d.dreq.we = 1'b1;
                     s_d.dreq.wdata = res;
                  end
               endcase
            end
            if (dec.jump)
            begin
               s_d.flush = 1'b1;
               if (dec.ret)
               begin
                  s_d.pc = s_q.stack0;
                  s_d.stack0 = s_q.stack1;
               end
               else
               begin
                  s_d.pc = (dec.call ? {3'b000, s_q.ir[7:0]}
                     : {2'b00, s_q.ir[8:0]}) & pc_mask;
                  if (dec.call)
                  begin
                     s_d.stack1 = s_q.stack0;
                     s_d.stack0 = s_q.pc;
                  end
               end
            end
         end
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
         s_q.pc <= PC_RESET[10:0] & PC_MASK;
         s_q.status <= STATUS_RST;
         s_q.flush <= 1'b1; // Nothing valid prefetched yet
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign prog_addr = s_q.pc;
   assign dmem_req = s_q.dreq;
   assign acc_out = s_q.acc;
   assign status_out = s_q.status;
   assign cycle_rate_output = s_q.clk_out;

endmodule : harvard_core

`default_nettype wire

//--- core_pkg.sv
package core_pkg;

   // ****************************************************
   // Widths
   // ****************************************************
   localparam int unsigned INSN_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FADDR_W = 5;
   localparam int unsigned PROG_WORDS_DEF = 512;
   localparam int unsigned QUARTERS = 4;

   // ****************************************************
   // File register map
   // ****************************************************
   localparam logic [4:0] F_INDIRECT = 5'h00;
   localparam logic [4:0] F_TIMER = 5'h01;
   localparam logic [4:0] F_PCL = 5'h02;
   localparam logic [4:0] F_STATUS = 5'h03;
   localparam logic [4:0] F_POINTER = 5'h04;

   // Flag positions in the status register
   localparam int unsigned ST_OVF = 0;
   localparam int unsigned ST_NIB = 1;
   localparam int unsigned ST_NULL = 2;

   // Status reset value and no-op word
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [11:0] NOP_WORD = 12'h000;

   // ****************************************************
   // Reset address and opcode fields
   // ****************************************************
   localparam logic [11:0] PC_RESET = 12'hfff;
   localparam logic [5:0] OP_ADD_F = 6'h07;
   localparam logic [5:0] OP_SUB_F = 6'h02;

   typedef enum logic [3:0] {
      ALU_PASS_B, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
      ALU_COM, ALU_INC, ALU_DEC, ALU_RLF, ALU_RRF, ALU_SWAP, ALU_CLR
   } alu_op_t;

   // Decoded instruction
   typedef struct packed {
      alu_op_t op;
      logic use_imm;
      logic to_file;
      logic wr_acc;
      logic set_ovf;
      logic set_nib;
      logic set_null;
      logic jump;
      logic call;
      logic ret;
      logic skip_zero;
   } dec_t;

   // Data memory port
   typedef struct packed {
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic we;
   } dmem_req_t;

endpackage : core_pkg

//--- harvard_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// Program and file memory beside the core
// ****
module harvard_mem_model
   import core_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Program side
   input wire logic [10:0] prog_addr,
   output logic [INSN_W-1:0] prog_data,
   // File side
   input wire dmem_req_t dmem_req,
   output logic [DATA_W-1:0] dmem_rdata
);
   logic [INSN_W-1:0] prog_mem [0:2047];
   logic [DATA_W-1:0] file_mem [0:31];

   // Whole word per fetch on its own bus, all of it on chip
   assign prog_data = prog_mem[prog_addr];
   // Reads follow the address within the cycle
   assign dmem_rdata = file_mem[dmem_req.addr];
   // A write lands on the edge that ends its pulse
   always @(posedge ref_clk)
   begin
      if (dmem_req.we)
         file_mem[dmem_req.addr] <= dmem_req.wdata;
   end
endmodule : harvard_mem_model

`default_nettype wire

//--- harvard_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// Port checker
// ****
module harvard_core_monitor
   import core_pkg::*;
#(
   parameter int unsigned PROG_WORDS = PROG_WORDS_DEF
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Watched ports
   input wire logic rc_mode,
   input wire logic [10:0] prog_addr,
   input wire logic [INSN_W-1:0] prog_data,
   input wire dmem_req_t dmem_req,
   input wire logic [DATA_W-1:0] dmem_rdata,
   input wire logic [DATA_W-1:0] acc_out,
   input wire logic [DATA_W-1:0] status_out,
   input wire logic cycle_rate_output
);
   logic [1:0] phase_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Own quarter count, so a slipped phase in the core shows
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         phase_q <= 2'h0;
      else
         phase_q <= phase_q + 2'h1;
   end

   // Reset state and first fetch
   reset_state_a: assert property (
      $rose(rst_n) |-> prog_addr == 11'(PROG_WORDS - 1) && acc_out == 8'h00)
      else $error("bad reset state");
   first_fetch_a: assert property (
      $rose(rst_n) |-> ##3 prog_addr == 11'(PROG_WORDS - 1) ##1 prog_addr == 11'h000)
      else $error("first fetch late or early");
   addr_range_a: assert property (
      prog_addr < 11'(PROG_WORDS))
      else $error("program address beyond space");
   // Program address, file write and accumulator move on the execute edge only
   fetch_phase_a: assert property (
      $changed(prog_addr) |-> phase_q == 2'h0)
      else $error("fetch off its quarter");
   write_pulse_a: assert property (
      dmem_req.we |-> phase_q == 2'h0 ##1 !dmem_req.we [*3])
      else $error("file write not a lone pulse");
   acc_phase_a: assert property (
      $changed(acc_out) |-> phase_q == 2'h0)
      else $error("accumulator moved mid cycle");
   // Cycle-rate output, strap settled first
   rate_out_a: assert property (
      disable iff (!rst_n || !rc_mode)
      rc_mode [*6] ##0 $rose(cycle_rate_output) |=>
         cycle_rate_output ##1 !cycle_rate_output [*2] ##1 cycle_rate_output)
      else $error("cycle-rate output not a quarter rate");
   rate_off_a: assert property (
      !rc_mode [*5] |-> !cycle_rate_output)
      else $error("cycle-rate output outside RC mode");

   cover property ($rose(dmem_req.we));
   cover property (dmem_req.we && status_out[ST_OVF]);
   cover property ($rose(cycle_rate_output));
endmodule : harvard_core_monitor

bind harvard_core harvard_core_monitor #(.PROG_WORDS(PROG_WORDS)) u_monitor (
   .ref_clk(ref_clk), .rst_n(rst_n), .rc_mode(rc_mode), .prog_addr(prog_addr),
   .prog_data(prog_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
   .acc_out(acc_out), .status_out(status_out), .cycle_rate_output(cycle_rate_output));

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
   import core_pkg::*;
;
   localparam int N = 24;
   localparam logic [63:0] CORNER = 64'h0000_01ff_0f02_0580;
   logic ref_clk = 1'b0;
   logic rst_n;
   logic rc_mode;
   logic [10:0] prog_addr;
   logic [INSN_W-1:0] prog_data;
   dmem_req_t dmem_req;
   logic [DATA_W-1:0] dmem_rdata;
   logic [DATA_W-1:0] acc_out;
   logic [DATA_W-1:0] status_out;
   logic cycle_rate_output;
   int fail_count = 0;
   int samples_checked = 0;

   // 50 MHz reference
   always #10 ref_clk = ~ref_clk;

   harvard_core #(.PROG_WORDS(512)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .rc_mode(rc_mode), .prog_addr(prog_addr),
      .prog_data(prog_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
      .acc_out(acc_out), .status_out(status_out), .cycle_rate_output(cycle_rate_output));
   harvard_mem_model u_mem (.ref_clk(ref_clk), .prog_addr(prog_addr),
      .prog_data(prog_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

   // Expected {zero, nibble, carry, result}; carry means no borrow on subtract
   function automatic logic [10:0] alu_exp(input logic sub, input logic [7:0] f, w);
      logic [8:0] r;
      logic nib;
      r = sub ? {1'b0, f} - {1'b0, w} : {1'b0, f} + {1'b0, w};
      nib = sub ? (f[3:0] >= w[3:0]) : ({1'b0, f[3:0]} + {1'b0, w[3:0]} > 5'h0f);
      return {r[7:0] == 8'h00, nib, sub ? ~r[8] : r[8], r[7:0]};
   endfunction : alu_exp

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   // Hold reset ten cycles and look at the outputs inside it
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (10) @(negedge ref_clk);
      check({5'h00, prog_addr}, 16'h01ff);
      check({acc_out, status_out}, {8'h00, STATUS_RST});
      check({15'h0000, dmem_req.we}, 16'h0000);
      rst_n = 1'b1;
      $display("test reset done");
   endtask : do_reset

   // Rising edges of the cycle-rate output over ten instruction cycles
   task automatic count_rises(input logic mode, input int exp);
      int n;
      logic prev;
      n = 0;
      rc_mode = mode;
      repeat (8) @(negedge ref_clk);
      prev = cycle_rate_output;
      repeat (40)
      begin
         @(negedge ref_clk);
         n += (cycle_rate_output === 1'b1 && prev !== 1'b1) ? 1 : 0;
         prev = cycle_rate_output;
      end
      check(16'(n), 16'(exp));
      $display("test rate done");
   endtask : count_rises

   initial
   begin
      logic [7:0] fm [0:31];
      logic [7:0] w;
      logic [10:0] r;
      logic [4:0] a;
      logic [4:0] b;
      logic [15:0] exp_q [$];
      int got;
      rst_n = 1'b0;
      rc_mode = 1'b1;
      void'($urandom(12));
      for (int i = 0; i < 2048; i++)
         u_mem.prog_mem[i] = NOP_WORD;
      for (int i = 0; i < 32; i++)
         fm[i] = 8'($urandom);
      // Fixed operands first: zero, carry, nibble carry, borrow
      for (int k = 0; k < 8; k++)
         fm[8 + k] = CORNER[63 - 8 * k -: 8];
      for (int i = 0; i < 32; i++)
         u_mem.file_mem[i] = fm[i];
      // Reset word jumps to zero; a kept prefetch would run word zero twice
      u_mem.prog_mem[511] = {3'b101, 9'h000};
      w = 8'h00;
      for (int i = 0; i < N; i++)
      begin
         a = (i < 4) ? 5'(8 + 2 * i) : 5'(8 + $urandom_range(23));
         b = (i < 4) ? 5'(9 + 2 * i) : 5'(8 + $urandom_range(23));
         u_mem.prog_mem[2 * i] = {OP_SUB_F, 1'b0, a};
         u_mem.prog_mem[2 * i + 1] = {OP_ADD_F, 1'b1, b};
         r = alu_exp(1'b1, fm[a], w);
         w = r[7:0];
         r = alu_exp(1'b0, fm[b], w);
         fm[b] = r[7:0];
         exp_q.push_back({b, r});
      end
      u_mem.prog_mem[2 * N] = {OP_SUB_F, 1'b0, 5'h1f};
      r = alu_exp(1'b1, fm[31], w);
      do_reset();
      got = 0;
      for (int c = 0; c < 2000 && got < N; c++)
      begin
         @(negedge ref_clk);
         if (dmem_req.we === 1'b1)
         begin
            check({dmem_req.addr, status_out[2:0], dmem_req.wdata}, exp_q[got]);
            got++;
         end
      end
      if (got < N)
      begin
         // Missing writes count as a mismatch and go straight to the report
         fail_count++;
      end
      else
      begin
         repeat (12) @(negedge ref_clk);
         check({acc_out, status_out}, {r[7:0], STATUS_RST[7:3], r[10:8]});
         $display("test program done");
         count_rises(1'b1, 10);
         count_rises(1'b0, 0);
         do_reset();
      end
      report_and_stop();
   end
endmodule : tb

`default_nettype wire
